// ### logic/canirq_regs.vh
// register offsets, field positions and reset values of the can interrupt and queue slice
`ifndef CANIRQ_REGS_VH
`define CANIRQ_REGS_VH

`define CANIRQ_OFF_RX1_STATUS   12'h010
`define CANIRQ_OFF_IRQ_ENABLE   12'h014
`define CANIRQ_OFF_EVT_STATUS   12'h020
`define CANIRQ_OFF_TIMER        12'h024
`define CANIRQ_OFF_CONTROL      12'h028
`define CANIRQ_OFF_TX0_LEN_TIME 12'h184
`define CANIRQ_OFF_TX0_DATA_LO  12'h188
`define CANIRQ_OFF_TX0_DATA_HI  12'h18C
`define CANIRQ_OFF_TX1_IDENT    12'h190

`define CANIRQ_IER_MASK         32'h0003_8F7F
`define CANIRQ_IER_RESET        32'h0000_0000

`define CANIRQ_BIT_SLEEP        17
`define CANIRQ_BIT_WAKEUP       16
`define CANIRQ_BIT_ERROR        15
`define CANIRQ_BIT_LEC          11
`define CANIRQ_BIT_BUS_OFF      10
`define CANIRQ_BIT_PASSIVE      9
`define CANIRQ_BIT_WARNING      8
`define CANIRQ_BIT_Q1_OVERRUN   6
`define CANIRQ_BIT_Q1_FULL      5
`define CANIRQ_BIT_Q1_PENDING   4
`define CANIRQ_BIT_Q0_OVERRUN   3
`define CANIRQ_BIT_Q0_FULL      2
`define CANIRQ_BIT_Q0_PENDING   1
`define CANIRQ_BIT_TX_EMPTY     0

`define CANIRQ_RX1_FULL_BIT     3
`define CANIRQ_RX1_RELEASE_BIT  5
`define CANIRQ_RX1_OVERRUN_BIT  4
`define CANIRQ_QUEUE_DEPTH      2'd3

`define CANIRQ_TGT_BIT          8
`define CANIRQ_DLC_MSB          3
`define CANIRQ_CTRL_NO_RETRY    0

`define CANIRQ_RESP_OKAY        2'b00
`define CANIRQ_RESP_SLVERR      2'b10

`endif

// ### logic/canirq_core.v
// can interrupt, receive queue 1 status, time stamp and mailbox register slice
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "canirq_regs.vh"

module canirq_core #(
	parameter TIMER_WIDTH = 16
) (
	input  wire                   aclk,
	input  wire                   aresetn,
	// axi4-lite slave
	input  wire [11:0]            s_axi_awaddr,
	input  wire                   s_axi_awvalid,
	output reg                    s_axi_awready,
	input  wire [31:0]            s_axi_wdata,
	input  wire [3:0]             s_axi_wstrb,
	input  wire                   s_axi_wvalid,
	output reg                    s_axi_wready,
	output reg  [1:0]             s_axi_bresp,
	output reg                    s_axi_bvalid,
	input  wire                   s_axi_bready,
	input  wire [11:0]            s_axi_araddr,
	input  wire                   s_axi_arvalid,
	output reg                    s_axi_arready,
	output reg  [31:0]            s_axi_rdata,
	output reg  [1:0]             s_axi_rresp,
	output reg                    s_axi_rvalid,
	input  wire                   s_axi_rready,
	// events from protocol, mode and error logic
	input  wire                   queue1_store,
	input  wire                   queue0_store,
	input  wire                   queue0_full,
	input  wire                   queue0_overrun,
	input  wire                   queue1_overrun_in,
	input  wire                   tx_mailbox_empty,
	input  wire                   tx_sof,
	input  wire                   rx_sof,
	input  wire                   tx_failed,
	input  wire                   sleep_ack_flag,
	input  wire                   wakeup_flag,
	input  wire                   warning_flag,
	input  wire                   error_passive_flag,
	input  wire                   bus_off_flag,
	input  wire                   lec_write,
	input  wire [2:0]             last_error_code,
	// to the frame engine, plus the interrupt line
	output reg  [TIMER_WIDTH-1:0] rx_time_stamp,
	output reg                    rx_stamp_valid,
	output reg  [31:0]            tx0_frame_data_high,
	output reg                    tx_retry,
	output reg                    irq
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function [31:0] apply_strobe;
		input [31:0] old_value;
		input [31:0] new_value;
		input [3:0]  strobe;
		integer      i;
		begin
			apply_strobe = old_value;
			for (i = 0; i < 4; i = i + 1) begin
				if (strobe[i]) begin
					apply_strobe[i*8 +: 8] = new_value[i*8 +: 8];
				end
			end
		end
	endfunction

	function addr_known;
		input [11:0] addr;
		begin
			case (addr)
				`CANIRQ_OFF_RX1_STATUS, `CANIRQ_OFF_IRQ_ENABLE, `CANIRQ_OFF_EVT_STATUS,
				`CANIRQ_OFF_TIMER, `CANIRQ_OFF_CONTROL, `CANIRQ_OFF_TX0_LEN_TIME,
				`CANIRQ_OFF_TX0_DATA_LO, `CANIRQ_OFF_TX0_DATA_HI,
				`CANIRQ_OFF_TX1_IDENT: addr_known = 1'b1;
				default: addr_known = 1'b0;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	reg [31:0]            interrupt_enable;
	reg [31:0]            evt_status;
	reg [31:0]            tx_mailbox0_length_time;
	reg [31:0]            tx_mailbox0_data_low;
	reg [31:0]            tx_mailbox0_data_high;
	reg [31:0]            tx_mailbox1_identifier;
	reg [TIMER_WIDTH-1:0] free_timer;
	reg [1:0]             queue1_pending_count;
	reg                   queue1_full_flag;
	reg                   queue1_overrun;
	reg                   no_retry_mode;
	reg                   bus_off_prev;
	reg                   passive_prev;
	reg [11:0]            aw_addr;
	reg                   aw_held;
	reg [31:0]            w_data;
	reg [3:0]             w_strb;
	reg                   w_held;

	wire        aw_take = s_axi_awvalid & s_axi_awready;
	wire        w_take  = s_axi_wvalid & s_axi_wready;
	wire        do_write = aw_held & w_held & ~s_axi_bvalid;
	wire        wr_rx1  = do_write & (aw_addr == `CANIRQ_OFF_RX1_STATUS);
	wire        queue1_release = wr_rx1 & w_strb[0] & w_data[`CANIRQ_RX1_RELEASE_BIT];
	wire        full_clr       = wr_rx1 & w_strb[0] & w_data[`CANIRQ_RX1_FULL_BIT];
	wire        overrun_clr    = wr_rx1 & w_strb[0] & w_data[`CANIRQ_RX1_OVERRUN_BIT];
	wire        do_store       = queue1_store & (queue1_pending_count != `CANIRQ_QUEUE_DEPTH);
	wire [11:0] rd_addr        = {s_axi_araddr[11:2], 2'b00};

	// ------------------------------------------------------------
	// queue 1 controls
	// ------------------------------------------------------------
	// a release on an empty queue is dropped so the count cannot wrap to three
	wire        count_nonzero  = (queue1_pending_count != 2'd0);
	wire        do_release     = queue1_release & count_nonzero;
	// store and release together leave a count of one or two where it is
	wire        count_up       = do_store & ~do_release;
	wire        count_down     = do_release & ~do_store;
	wire        full_set       = do_store &
		(queue1_pending_count == `CANIRQ_QUEUE_DEPTH - 2'd1);
	// a store into a full queue is lost and flagged
	wire        overrun_set    = queue1_overrun_in | (queue1_store & ~do_store);

	// ------------------------------------------------------------
	// error sources for status bit 15
	// ------------------------------------------------------------
	wire        err_lec        = interrupt_enable[`CANIRQ_BIT_LEC] & lec_write &
		(last_error_code != 3'd0);
	wire        err_bus_off    = interrupt_enable[`CANIRQ_BIT_BUS_OFF] & bus_off_flag &
		~bus_off_prev;
	wire        err_passive    = interrupt_enable[`CANIRQ_BIT_PASSIVE] & error_passive_flag &
		~passive_prev;
	// warning is a level, so it re-sets bit 15 for as long as it stands
	wire        err_warning    = interrupt_enable[`CANIRQ_BIT_WARNING] & warning_flag;

	// ------------------------------------------------------------
	// time stamp counter
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			free_timer     <= {TIMER_WIDTH{1'b0}};
			rx_time_stamp  <= {TIMER_WIDTH{1'b0}};
			rx_stamp_valid <= 1'b0;
		end else begin
			free_timer     <= free_timer + 1'b1;
			rx_stamp_valid <= rx_sof;
			if (rx_sof) begin
				rx_time_stamp <= free_timer;
			end
		end
	end

	// ------------------------------------------------------------
	// receive queue 1 status
	// ------------------------------------------------------------
	// the counter saturates at three; a store into a full queue is an overrun
	always @(posedge aclk) begin
		if (!aresetn) begin
			queue1_pending_count <= 2'd0;
			queue1_full_flag     <= 1'b0;
			queue1_overrun       <= 1'b0;
		end else begin
			if (count_up) begin
				queue1_pending_count <= queue1_pending_count + 2'd1;
			end else if (count_down) begin
				queue1_pending_count <= queue1_pending_count - 2'd1;
			end
			if (full_set) begin
				queue1_full_flag <= 1'b1;
			end else if (full_clr) begin
				queue1_full_flag <= 1'b0;
			end
			if (overrun_set) begin
				queue1_overrun <= 1'b1;
			end else if (overrun_clr) begin
				queue1_overrun <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// event status and interrupt
	// ------------------------------------------------------------
	reg [31:0] next_evt;
	reg [31:0] evt_set;
	always @* begin
		evt_set = 32'h0000_0000;
		evt_set[`CANIRQ_BIT_SLEEP]      = sleep_ack_flag;
		evt_set[`CANIRQ_BIT_WAKEUP]     = wakeup_flag;
		evt_set[`CANIRQ_BIT_ERROR]      = err_lec | err_bus_off | err_passive |
			err_warning;
		evt_set[`CANIRQ_BIT_Q1_OVERRUN] = queue1_overrun;
		evt_set[`CANIRQ_BIT_Q1_FULL]    = queue1_full_flag;
		evt_set[`CANIRQ_BIT_Q1_PENDING] = queue1_pending_count != 2'd0;
		evt_set[`CANIRQ_BIT_Q0_OVERRUN] = queue0_overrun;
		evt_set[`CANIRQ_BIT_Q0_FULL]    = queue0_full;
		evt_set[`CANIRQ_BIT_Q0_PENDING] = queue0_store;
		evt_set[`CANIRQ_BIT_TX_EMPTY]   = tx_mailbox_empty;
		next_evt = evt_status;
		if (do_write && aw_addr == `CANIRQ_OFF_EVT_STATUS) begin
			next_evt = next_evt & ~apply_strobe(32'h0000_0000, w_data, w_strb);
		end
		// set wins over a same-cycle clear
		next_evt = (next_evt | evt_set) & `CANIRQ_IER_MASK;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			evt_status   <= 32'h0000_0000;
			bus_off_prev <= 1'b0;
			passive_prev <= 1'b0;
			irq          <= 1'b0;
		end else begin
			evt_status   <= next_evt;
			bus_off_prev <= bus_off_flag;
			passive_prev <= error_passive_flag;
			irq          <= |(next_evt & interrupt_enable);
		end
	end

	// ------------------------------------------------------------
	// mailbox and configuration registers
	// ------------------------------------------------------------
	// frames themselves are built by the protocol engine from these fields
	always @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_enable        <= `CANIRQ_IER_RESET;
			tx_mailbox0_length_time <= 32'h0000_0000;
			tx_mailbox0_data_low    <= 32'h0000_0000;
			tx_mailbox0_data_high   <= 32'h0000_0000;
			tx_mailbox1_identifier  <= 32'h0000_0000;
			no_retry_mode           <= 1'b0;
			tx0_frame_data_high     <= 32'h0000_0000;
			tx_retry                <= 1'b0;
		end else begin
			if (do_write) begin
				case (aw_addr)
					`CANIRQ_OFF_IRQ_ENABLE: interrupt_enable <=
						apply_strobe(interrupt_enable, w_data, w_strb) & `CANIRQ_IER_MASK;
					`CANIRQ_OFF_CONTROL: if (w_strb[0]) begin
						no_retry_mode <= w_data[`CANIRQ_CTRL_NO_RETRY];
					end
					`CANIRQ_OFF_TX0_LEN_TIME: tx_mailbox0_length_time <=
						apply_strobe(tx_mailbox0_length_time, w_data, w_strb);
					`CANIRQ_OFF_TX0_DATA_LO: tx_mailbox0_data_low <=
						apply_strobe(tx_mailbox0_data_low, w_data, w_strb);
					`CANIRQ_OFF_TX0_DATA_HI: tx_mailbox0_data_high <=
						apply_strobe(tx_mailbox0_data_high, w_data, w_strb);
					`CANIRQ_OFF_TX1_IDENT: tx_mailbox1_identifier <=
						apply_strobe(tx_mailbox1_identifier, w_data, w_strb);
					default: begin
					end
				endcase
			end else if (tx_sof) begin
				tx_mailbox0_length_time[31:16] <= free_timer;
			end
			tx_retry <= tx_failed & ~no_retry_mode;
			// stamp lands in bytes 6 and 7 when time-triggered
			if (tx_mailbox0_length_time[`CANIRQ_TGT_BIT]) begin
				tx0_frame_data_high <= {tx_mailbox0_length_time[31:16],
					tx_mailbox0_data_high[15:0]};
			end else begin
				tx0_frame_data_high <= tx_mailbox0_data_high;
			end
		end
	end

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CANIRQ_RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 12'h000;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
		end else begin
			s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_bvalid;
			s_axi_wready  <= ~w_held & ~w_take & ~s_axi_bvalid;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[11:2], 2'b00};
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_known(aw_addr) ? `CANIRQ_RESP_OKAY : `CANIRQ_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	reg [31:0] read_word;
	always @* begin
		case (rd_addr)
			`CANIRQ_OFF_RX1_STATUS: read_word = {28'h0000000, queue1_full_flag, 1'b0,
				queue1_pending_count} | {27'h0, queue1_overrun, 4'h0};
			`CANIRQ_OFF_IRQ_ENABLE:   read_word = interrupt_enable;
			`CANIRQ_OFF_EVT_STATUS:   read_word = evt_status;
			`CANIRQ_OFF_TIMER:        read_word = {{(32-TIMER_WIDTH){1'b0}}, free_timer};
			`CANIRQ_OFF_CONTROL:      read_word = {31'h0, no_retry_mode};
			`CANIRQ_OFF_TX0_LEN_TIME: read_word = tx_mailbox0_length_time;
			`CANIRQ_OFF_TX0_DATA_LO:  read_word = tx_mailbox0_data_low;
			`CANIRQ_OFF_TX0_DATA_HI:  read_word = tx_mailbox0_data_high;
			`CANIRQ_OFF_TX1_IDENT:    read_word = tx_mailbox1_identifier;
			default:                  read_word = 32'h0000_0000;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `CANIRQ_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= read_word;
				s_axi_rresp  <= addr_known(rd_addr) ?
					`CANIRQ_RESP_OKAY : `CANIRQ_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// ### bench/canirq_properties.sv
// port-level assertions for the can interrupt and queue slice
`timescale 1ns/1ps
`include "canirq_regs.vh"
module canirq_properties #(
	parameter TIMER_WIDTH = 16
) (
	input wire                   aclk,
	input wire                   aresetn,
	input wire                   s_axi_awvalid,
	input wire                   s_axi_awready,
	input wire                   s_axi_wvalid,
	input wire                   s_axi_wready,
	input wire [1:0]             s_axi_bresp,
	input wire                   s_axi_bvalid,
	input wire                   s_axi_bready,
	input wire [11:0]            s_axi_araddr,
	input wire                   s_axi_arvalid,
	input wire                   s_axi_arready,
	input wire [31:0]            s_axi_rdata,
	input wire [1:0]             s_axi_rresp,
	input wire                   s_axi_rvalid,
	input wire                   rx_sof,
	input wire                   tx_failed,
	input wire [TIMER_WIDTH-1:0] rx_time_stamp,
	input wire                   rx_stamp_valid,
	input wire                   tx_retry,
	input wire                   irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_stamp_valid; rx_sof |=> rx_stamp_valid; endproperty
	a_stamp_valid: assert property (p_stamp_valid) else $error("stamp valid missing");
	property p_stamp_cause; rx_stamp_valid |-> $past(rx_sof); endproperty
	a_stamp_cause: assert property (p_stamp_cause) else $error("stray stamp valid");
	property p_timer_step;
		rx_sof ##1 rx_sof |=> rx_time_stamp == $past(rx_time_stamp) + 1'h1;
	endproperty
	a_timer_step: assert property (p_timer_step) else $error("timer did not step by one");
	property p_retry_cause; tx_retry |-> $past(tx_failed); endproperty
	a_retry_cause: assert property (p_retry_cause) else $error("retry without failure");
	property p_bresp_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
	property p_write_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("late write response");
	property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_read_answer: assert property (p_read_answer) else $error("late read data");
	property p_unmapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h0FC
			|=> s_axi_rresp == `CANIRQ_RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	// irq may only fall after software cleared a flag or an enable
	property p_irq_hold;
		$fell(irq) |-> $past(s_axi_wvalid && s_axi_wready) ||
			$past(s_axi_wvalid && s_axi_wready, 2);
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq fell without a write");
endmodule

// ### bench/canirq_node.sv
// far-side event source standing in for the frame engine and other bus nodes
`timescale 1ns/1ps
module canirq_node (
	input wire aclk,
	output reg queue1_store,
	output reg queue0_store,
	output reg rx_sof,
	output reg tx_sof,
	output reg tx_failed
);
	initial {tx_failed, tx_sof, rx_sof, queue0_store, queue1_store} = 5'h00;
	// held for n cycles: n stores or frames back to back, or one slow event
	task pulse(input [4:0] m, input int n);
		@(posedge aclk);
		{tx_failed, tx_sof, rx_sof, queue0_store, queue1_store} <= m;
		repeat (n) @(posedge aclk);
		{tx_failed, tx_sof, rx_sof, queue0_store, queue1_store} <= 5'h00;
	endtask
endmodule

// ### bench/canirq_tb.sv
// self-checking bench for the can interrupt and queue slice
`timescale 1ns/1ps
`include "canirq_regs.vh"
`define CHK(g, e) begin \
	n_tests++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); \
	end \
end
module testbench;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, queue1_store, queue0_store, queue0_full, queue0_overrun;
	logic        queue1_overrun_in, tx_mailbox_empty, tx_sof, rx_sof, tx_failed;
	logic        sleep_ack_flag, wakeup_flag, warning_flag, error_passive_flag;
	logic        bus_off_flag, lec_write, rx_stamp_valid, tx_retry, irq;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data, tx0_frame_data_high;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [2:0]  last_error_code;
	logic [15:0] rx_time_stamp;
	int          errors, n_tests, cyc;
	canirq_core #(
		.TIMER_WIDTH(16)
	) dut_u (
		.aclk                (aclk),
		.aresetn             (aresetn),
		.s_axi_awaddr        (s_axi_awaddr),
		.s_axi_awvalid       (s_axi_awvalid),
		.s_axi_awready       (s_axi_awready),
		.s_axi_wdata         (s_axi_wdata),
		.s_axi_wstrb         (s_axi_wstrb),
		.s_axi_wvalid        (s_axi_wvalid),
		.s_axi_wready        (s_axi_wready),
		.s_axi_bresp         (s_axi_bresp),
		.s_axi_bvalid        (s_axi_bvalid),
		.s_axi_bready        (s_axi_bready),
		.s_axi_araddr        (s_axi_araddr),
		.s_axi_arvalid       (s_axi_arvalid),
		.s_axi_arready       (s_axi_arready),
		.s_axi_rdata         (s_axi_rdata),
		.s_axi_rresp         (s_axi_rresp),
		.s_axi_rvalid        (s_axi_rvalid),
		.s_axi_rready        (s_axi_rready),
		.queue1_store        (queue1_store),
		.queue0_store        (queue0_store),
		.queue0_full         (queue0_full),
		.queue0_overrun      (queue0_overrun),
		.queue1_overrun_in   (queue1_overrun_in),
		.tx_mailbox_empty    (tx_mailbox_empty),
		.tx_sof              (tx_sof),
		.rx_sof              (rx_sof),
		.tx_failed           (tx_failed),
		.sleep_ack_flag      (sleep_ack_flag),
		.wakeup_flag         (wakeup_flag),
		.warning_flag        (warning_flag),
		.error_passive_flag  (error_passive_flag),
		.bus_off_flag        (bus_off_flag),
		.lec_write           (lec_write),
		.last_error_code     (last_error_code),
		.rx_time_stamp       (rx_time_stamp),
		.rx_stamp_valid      (rx_stamp_valid),
		.tx0_frame_data_high (tx0_frame_data_high),
		.tx_retry            (tx_retry),
		.irq                 (irq)
	);
	canirq_node node_u (
		.aclk         (aclk),
		.queue1_store (queue1_store),
		.queue0_store (queue0_store),
		.rx_sof       (rx_sof),
		.tx_sof       (tx_sof),
		.tx_failed    (tx_failed)
	);
	always #2 aclk = ~aclk;
	// cut a hang short well past the few hundred cycles the tests need
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			complete_run;
		end
	end
	task wr(input [11:0] a, input [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task rd(input [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		{resp, rd_data} = {s_axi_rresp, s_axi_rdata};
		s_axi_rready <= 1'h0;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		rd(`CANIRQ_OFF_IRQ_ENABLE);
		`CHK(rd_data, `CANIRQ_IER_RESET)
		wr(`CANIRQ_OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
		rd(`CANIRQ_OFF_IRQ_ENABLE);
		`CHK(rd_data, `CANIRQ_IER_MASK)
		wr(12'h0FC, 32'h1);
		`CHK(resp, `CANIRQ_RESP_SLVERR)
		rd(12'h0FC);
		`CHK({resp, rd_data}, {`CANIRQ_RESP_SLVERR, 32'h0})
		wr(`CANIRQ_OFF_IRQ_ENABLE, 32'h0);
		$display("regs done");
	endtask
	task t_queue;
		node_u.pulse(5'h01, 3);
		rd(`CANIRQ_OFF_RX1_STATUS);
		`CHK(rd_data[4:0], 5'h0B)
		node_u.pulse(5'h01, 1);
		rd(`CANIRQ_OFF_RX1_STATUS);
		`CHK(rd_data[4:0], 5'h1B)
		wr(`CANIRQ_OFF_RX1_STATUS, 32'h20);
		rd(`CANIRQ_OFF_RX1_STATUS);
		`CHK(rd_data[4:0], 5'h1A)
		wr(`CANIRQ_OFF_RX1_STATUS, 32'h18);
		rd(`CANIRQ_OFF_RX1_STATUS);
		`CHK(rd_data[4:0], 5'h02)
		wr(`CANIRQ_OFF_IRQ_ENABLE, 32'h10);
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'h1)
		// pending is a level: drain the queue before clearing its status bit
		wr(`CANIRQ_OFF_RX1_STATUS, 32'h20);
		wr(`CANIRQ_OFF_RX1_STATUS, 32'h20);
		rd(`CANIRQ_OFF_RX1_STATUS);
		`CHK(rd_data[4:0], 5'h00)
		`CHK(irq, 1'h1)
		wr(`CANIRQ_OFF_EVT_STATUS, `CANIRQ_IER_MASK);
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'h0)
		wr(`CANIRQ_OFF_IRQ_ENABLE, 32'h0);
		$display("queue done");
	endtask
	task t_irq;
		for (int i = 0; i < 2; i++) begin
			@(posedge aclk);
			{sleep_ack_flag, wakeup_flag} <= 2'h2 >> i;
			repeat (3) @(posedge aclk);
			`CHK(irq, 1'h0)
			wr(`CANIRQ_OFF_IRQ_ENABLE, 32'h2_0000 >> i);
			repeat (2) @(posedge aclk);
			`CHK(irq, 1'h1)
			{sleep_ack_flag, wakeup_flag} <= 2'h0;
			wr(`CANIRQ_OFF_EVT_STATUS, 32'h2_0000 >> i);
			repeat (2) @(posedge aclk);
			`CHK(irq, 1'h0)
			wr(`CANIRQ_OFF_IRQ_ENABLE, 32'h0);
		end
		$display("irq done");
	endtask
	task t_err;
		for (int i = 0; i < 3; i++) begin
			wr(`CANIRQ_OFF_IRQ_ENABLE, 32'h8000 | (32'h200 << i));
			@(posedge aclk);
			{lec_write, bus_off_flag, error_passive_flag} <= 3'h1 << i;
			last_error_code <= 3'h5;
			@(posedge aclk);
			lec_write <= 1'h0;
			repeat (2) @(posedge aclk);
			`CHK(irq, 1'h1)
			{bus_off_flag, error_passive_flag} <= 2'h0;
			wr(`CANIRQ_OFF_EVT_STATUS, 32'h8000);
			repeat (2) @(posedge aclk);
			`CHK(irq, 1'h0)
		end
		wr(`CANIRQ_OFF_IRQ_ENABLE, 32'h0);
		$display("error done");
	endtask
	task t_stamp;
		wr(`CANIRQ_OFF_TX0_LEN_TIME, 32'h108);
		wr(`CANIRQ_OFF_TX0_DATA_HI, 32'hAABB_CCDD);
		node_u.pulse(5'h04, 2);
		node_u.pulse(5'h0C, 1);
		rd(`CANIRQ_OFF_TX0_LEN_TIME);
		`CHK(rd_data[31:16], rx_time_stamp)
		`CHK(tx0_frame_data_high, {rd_data[31:16], 16'hCCDD})
		wr(`CANIRQ_OFF_TX0_LEN_TIME, 32'h8);
		repeat (2) @(posedge aclk);
		`CHK(tx0_frame_data_high, 32'hAABB_CCDD)
		$display("stamp done");
	endtask
	task t_retry;
		node_u.pulse(5'h10, 1);
		@(posedge aclk);
		`CHK(tx_retry, 1'h1)
		wr(`CANIRQ_OFF_CONTROL, 32'h1);
		node_u.pulse(5'h10, 1);
		@(posedge aclk);
		`CHK(tx_retry, 1'h0)
		wr(`CANIRQ_OFF_CONTROL, 32'h0);
		$display("retry done");
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		aclk = 1'h0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{queue0_full, queue0_overrun, queue1_overrun_in, tx_mailbox_empty} = 4'h0;
		{sleep_ack_flag, wakeup_flag, warning_flag, error_passive_flag} = 4'h0;
		{bus_off_flag, lec_write, last_error_code} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hF;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_regs;
		t_queue;
		t_irq;
		t_err;
		t_stamp;
		t_retry;
		complete_run;
	end
endmodule
bind canirq_core canirq_properties #(
	.TIMER_WIDTH(TIMER_WIDTH)
) chk_u (
	.aclk           (aclk),
	.aresetn        (aresetn),
	.s_axi_awvalid  (s_axi_awvalid),
	.s_axi_awready  (s_axi_awready),
	.s_axi_wvalid   (s_axi_wvalid),
	.s_axi_wready   (s_axi_wready),
	.s_axi_bresp    (s_axi_bresp),
	.s_axi_bvalid   (s_axi_bvalid),
	.s_axi_bready   (s_axi_bready),
	.s_axi_araddr   (s_axi_araddr),
	.s_axi_arvalid  (s_axi_arvalid),
	.s_axi_arready  (s_axi_arready),
	.s_axi_rdata    (s_axi_rdata),
	.s_axi_rresp    (s_axi_rresp),
	.s_axi_rvalid   (s_axi_rvalid),
	.rx_sof         (rx_sof),
	.tx_failed      (tx_failed),
	.rx_time_stamp  (rx_time_stamp),
	.rx_stamp_valid (rx_stamp_valid),
	.tx_retry       (tx_retry),
	.irq            (irq)
);
